// ==== hdl/tcid3_access.sv ====
// trace capability id 3 register with system read access checks
`timescale 1ns/1ps
module tcid3_access
  import tcid3_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_rd_valid,
  input wire logic [1:0] i_op0,
  input wire logic [2:0] i_op1,
  input wire logic [3:0] i_crn,
  input wire logic [3:0] i_crm,
  input wire logic [2:0] i_op2,
  input wire logic [1:0] i_current_exception_level,
  input wire logic i_halted,
  input wire logic i_secure_debug_disable,
  input wire logic i_el1_trace_trap,
  input wire logic i_el2_trace_trap,
  input wire logic i_el3_trace_trap,
  input wire logic i_el2_enabled,
  input wire logic i_fine_grained_trap_enable,
  input wire logic i_trace_id_read_fine_trap,
  input wire logic i_cycle_count_trace_support,
  output logic o_rd_done,
  output logic [TCID3_W-1:0] o_rd_data,
  output logic o_undef,
  output logic o_trap,
  output logic [1:0] o_trap_el,
  output logic [5:0] o_trap_class
);
  logic [TCID3_W-1:0] value;
  tcid3_res_t res;
  logic [1:0] target;
  logic hit;
  logic ok;
  logic undef_w;
  logic trap_w;
  logic done_reg;
  logic undef_reg;
  logic trap_reg;
  logic [1:0] trap_el_reg;
  logic [5:0] trap_class_reg;
  logic [TCID3_W-1:0] data_reg;

  tcid3_value u_value (
    .i_cc_support(i_cycle_count_trace_support),
    .o_value(value)
  );

  tcid3_check u_check (
    .i_el(i_current_exception_level),
    .i_halted(i_halted),
    .i_sdd(i_secure_debug_disable),
    .i_el1_tta(i_el1_trace_trap),
    .i_el2_tta(i_el2_trace_trap),
    .i_el3_tta(i_el3_trace_trap),
    .i_el2_en(i_el2_enabled),
    .i_fgt_en(i_fine_grained_trap_enable),
    .i_fine_trap(i_trace_id_read_fine_trap),
    .o_res(res),
    .o_target(target)
  );

  // only the read encoding decodes; no write path exists
  assign hit = i_rd_valid && i_op0 == TCID3_OP0 && i_op1 == TCID3_OP1
    && i_crn == TCID3_CRN && i_crm == TCID3_CRM && i_op2 == TCID3_OP2;
  assign ok = hit && res == TCID3_RES_OK;
  assign undef_w = hit && res == TCID3_RES_UNDEF;
  assign trap_w = hit && res == TCID3_RES_TRAP;

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      done_reg <= 1'b0;
      undef_reg <= 1'b0;
      trap_reg <= 1'b0;
      trap_el_reg <= TCID3_EL0;
      trap_class_reg <= 6'h00;
      data_reg <= TCID3_ZERO;
    end
    else
    begin
      done_reg <= hit;
      undef_reg <= undef_w;
      trap_reg <= trap_w;
      trap_el_reg <= trap_w ? target : TCID3_EL0;
      trap_class_reg <= trap_w ? TCID3_EC_TRAP : 6'h00;
      data_reg <= ok ? value : TCID3_ZERO;
    end
  end

  assign o_rd_done = done_reg;
  assign o_undef = undef_reg;
  assign o_trap = trap_reg;
  assign o_trap_el = trap_el_reg;
  assign o_trap_class = trap_class_reg;
  assign o_rd_data = data_reg;
endmodule

// ==== hdl/tcid3_check.sv ====
// access check decision for a read
`timescale 1ns/1ps
module tcid3_check
  import tcid3_pkg::*;
(
  input wire logic [1:0] i_el,
  input wire logic i_halted,
  input wire logic i_sdd,
  input wire logic i_el1_tta,
  input wire logic i_el2_tta,
  input wire logic i_el3_tta,
  input wire logic i_el2_en,
  input wire logic i_fgt_en,
  input wire logic i_fine_trap,
  output tcid3_res_t o_res,
  output logic [1:0] o_target
);
  logic hsdd;
  assign hsdd = i_halted & i_sdd;
  always_comb
  begin
    o_res = TCID3_RES_OK;
    o_target = TCID3_EL1;
    case (i_el)
      TCID3_EL0: o_res = TCID3_RES_UNDEF;
      TCID3_EL1:
      begin
        if (hsdd && i_el3_tta)
          o_res = TCID3_RES_UNDEF;
        else if (i_el1_tta)
          o_res = TCID3_RES_TRAP;
        else if (i_el2_en && i_el2_tta)
        begin
          o_res = TCID3_RES_TRAP;
          o_target = TCID3_EL2;
        end
        else if (i_el2_en && i_fgt_en && i_fine_trap)
        begin
          o_res = TCID3_RES_TRAP;
          o_target = TCID3_EL2;
        end
        else if (i_el3_tta)
        begin
          o_res = hsdd ? TCID3_RES_UNDEF : TCID3_RES_TRAP;
          o_target = TCID3_EL3;
        end
      end
      TCID3_EL2:
      begin
        if (hsdd && i_el3_tta)
          o_res = TCID3_RES_UNDEF;
        else if (i_el2_tta)
        begin
          o_res = TCID3_RES_TRAP;
          o_target = TCID3_EL2;
        end
        else if (i_el3_tta)
        begin
          o_res = hsdd ? TCID3_RES_UNDEF : TCID3_RES_TRAP;
          o_target = TCID3_EL3;
        end
      end
      TCID3_EL3:
      begin
        if (i_el3_tta)
        begin
          o_res = TCID3_RES_TRAP;
          o_target = TCID3_EL3;
        end
      end
      default: o_res = TCID3_RES_UNDEF;
    endcase
  end
endmodule

// ==== hdl/tcid3_pkg.sv ====
// package for the trace capability id 3 access block
package tcid3_pkg;
  localparam int unsigned TCID3_W = 64;
  // read instruction encoding
  localparam logic [1:0] TCID3_OP0 = 2'h2;
  localparam logic [2:0] TCID3_OP1 = 3'h1;
  localparam logic [3:0] TCID3_CRN = 4'h0;
  localparam logic [3:0] TCID3_CRM = 4'hb;
  localparam logic [2:0] TCID3_OP2 = 3'h7;
  // field positions
  localparam int unsigned TCID3_OVF_POS = 31;
  localparam int unsigned TCID3_NUMHI_POS = 28;
  localparam int unsigned TCID3_STALL_PERMITTED_FLAG_POS = 27;
  localparam int unsigned TCID3_STALL_CONTROL_FLAG_POS = 26;
  localparam int unsigned TCID3_SYNC_POS = 25;
  localparam int unsigned TCID3_ERR_POS = 24;
  localparam int unsigned TCID3_NS_POS = 20;
  localparam int unsigned TCID3_S_POS = 16;
  localparam int unsigned TCID3_NUMLO_POS = 12;
  localparam int unsigned TCID3_MIN_POS = 0;
  // field values
  localparam logic TCID3_OVF_VAL = 1'b0;
  localparam logic TCID3_STALL_PERMITTED_FLAG_VAL = 1'b1;
  localparam logic TCID3_STALL_CONTROL_FLAG_VAL = 1'b1;
  localparam logic TCID3_SYNC_VAL = 1'b0;
  localparam logic TCID3_ERR_VAL = 1'b1;
  localparam logic [2:0] TCID3_NS_VAL = 3'h7;
  localparam logic [3:0] TCID3_S_VAL = 4'hf;
  localparam logic [4:0] TCID3_TRACED_CORE_COUNT_VAL = 5'h00;
  localparam logic [11:0] TCID3_MIN_ONE = 12'h001;
  localparam logic [11:0] TCID3_MIN_ZERO = 12'h000;
  // trap syndrome class
  localparam logic [5:0] TCID3_EC_TRAP = 6'h18;
  // exception levels
  localparam logic [1:0] TCID3_EL0 = 2'h0;
  localparam logic [1:0] TCID3_EL1 = 2'h1;
  localparam logic [1:0] TCID3_EL2 = 2'h2;
  localparam logic [1:0] TCID3_EL3 = 2'h3;
  localparam logic [TCID3_W-1:0] TCID3_ZERO = 64'h0;
  typedef enum logic [3:0] {
    TCID3_RES_OK = 4'b0001,
    TCID3_RES_UNDEF = 4'b0010,
    TCID3_RES_TRAP = 4'b0100,
    TCID3_RES_NONE = 4'b1000
  } tcid3_res_t;
endpackage

// ==== hdl/tcid3_value.sv ====
// builds the capability word, fixed apart from the minimum threshold field set by i_cc_support
`timescale 1ns/1ps
module tcid3_value
  import tcid3_pkg::*;
(
  input wire logic i_cc_support,
  output logic [TCID3_W-1:0] o_value
);
  logic [11:0] min_thr;
  assign min_thr = i_cc_support ? TCID3_MIN_ONE : TCID3_MIN_ZERO;
  always_comb
  begin
    o_value = TCID3_ZERO;
    o_value[TCID3_OVF_POS] = TCID3_OVF_VAL;
    o_value[TCID3_STALL_PERMITTED_FLAG_POS] = TCID3_STALL_PERMITTED_FLAG_VAL;
    o_value[TCID3_STALL_CONTROL_FLAG_POS] = TCID3_STALL_CONTROL_FLAG_VAL;
    o_value[TCID3_SYNC_POS] = TCID3_SYNC_VAL;
    o_value[TCID3_ERR_POS] = TCID3_ERR_VAL;
    o_value[TCID3_NS_POS +: 3] = TCID3_NS_VAL;
    o_value[TCID3_S_POS +: 4] = TCID3_S_VAL;
    o_value[TCID3_NUMLO_POS +: 2] = TCID3_TRACED_CORE_COUNT_VAL[1:0];
    o_value[TCID3_NUMHI_POS +: 3] = TCID3_TRACED_CORE_COUNT_VAL[4:2];
    o_value[TCID3_MIN_POS +: 12] = min_thr;
  end
endmodule

// ==== sim/tcid3_access_checker.sv ====
// assertions on the ports of the trace capability id 3 access block
`timescale 1ns/1ps
module tcid3_access_checker
  import tcid3_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_rd_valid,
  input wire logic [1:0] i_op0,
  input wire logic [2:0] i_op1,
  input wire logic [3:0] i_crn,
  input wire logic [3:0] i_crm,
  input wire logic [2:0] i_op2,
  input wire logic [1:0] i_current_exception_level,
  input wire logic i_halted,
  input wire logic i_secure_debug_disable,
  input wire logic i_el1_trace_trap,
  input wire logic i_el2_trace_trap,
  input wire logic i_el3_trace_trap,
  input wire logic i_cycle_count_trace_support,
  input wire logic o_rd_done,
  input wire logic [TCID3_W-1:0] o_rd_data,
  input wire logic o_undef,
  input wire logic o_trap,
  input wire logic [1:0] o_trap_el,
  input wire logic [5:0] o_trap_class
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  wire logic hit = i_rd_valid && ({i_op0, i_op1, i_crn, i_crm, i_op2}
    == {TCID3_OP0, TCID3_OP1, TCID3_CRN, TCID3_CRM, TCID3_OP2});
  wire logic hsd = i_halted && i_secure_debug_disable && i_el3_trace_trap;
  wire logic [1:0] el = i_current_exception_level;
  sequence s_trap(logic [1:0] t);
    o_rd_done && o_trap && !o_undef && o_trap_el == t && o_trap_class == TCID3_EC_TRAP;
  endsequence
  sequence s_undef;
    o_rd_done && o_undef && !o_trap && o_rd_data == TCID3_ZERO;
  endsequence
  AST_EL0_UNDEF: assert property (hit && el == TCID3_EL0 |=> s_undef)
    else $error("el0 read not undefined");
  AST_HALT_UNDEF: assert property (hit && el[1] != el[0] && hsd |=> s_undef)
    else $error("halted read not undefined");
  AST_EL1_TRAP: assert property (hit && el == TCID3_EL1 && !hsd && i_el1_trace_trap
    |=> s_trap(TCID3_EL1)) else $error("el1 trap wrong");
  AST_EL2_TRAP: assert property (hit && el == TCID3_EL2 && !hsd && i_el2_trace_trap
    |=> s_trap(TCID3_EL2)) else $error("el2 trap wrong");
  AST_EL3_TRAP: assert property (hit && el == TCID3_EL3 && i_el3_trace_trap
    |=> s_trap(TCID3_EL3)) else $error("el3 trap wrong");
  AST_VALUE: assert property (hit && el == TCID3_EL3 && !i_el3_trace_trap |=> o_rd_done
    && !o_trap && !o_undef && o_rd_data == (64'h0d7f0000 | $past(i_cycle_count_trace_support)))
    else $error("read value wrong");
  AST_MISS: assert property (!hit |=> !o_rd_done && !o_undef && !o_trap)
    else $error("answer without request");
  AST_IDLE: assert property (!o_rd_done |-> o_rd_data == TCID3_ZERO && o_trap_class == 6'h0)
    else $error("idle outputs not zero");
endmodule
bind tcid3_access tcid3_access_checker u_chk (.*);

// ==== sim/tcid3_access_tb.sv ====
// self-checking bench for the trace capability id 3 access block
`timescale 1ns/1ps
module tcid3_access_tb;
  import tcid3_pkg::*;
  logic i_mclk = 1'b0, i_rst = 1'b1, i_rd_valid = 1'b0, i_halted = 1'b0;
  logic i_secure_debug_disable = 1'b0, i_el1_trace_trap = 1'b0, i_el2_trace_trap = 1'b0;
  logic i_el3_trace_trap = 1'b0, i_el2_enabled = 1'b0, i_fine_grained_trap_enable = 1'b0;
  logic i_trace_id_read_fine_trap = 1'b0, i_cycle_count_trace_support = 1'b0;
  logic [1:0] i_op0 = 2'h0, i_current_exception_level = 2'h0;
  logic [2:0] i_op1 = 3'h0, i_op2 = 3'h0;
  logic [3:0] i_crn = 4'h0, i_crm = 4'h0;
  logic o_rd_done, o_undef, o_trap;
  logic [1:0] o_trap_el;
  logic [5:0] o_trap_class;
  logic [TCID3_W-1:0] o_rd_data;
  int fails = 0, cmp_count = 0;
  tcid3_access dut (.*);
  always #4 i_mclk = ~i_mclk;
  function automatic logic [27:0] mk(logic [1:0] el, logic [7:0] b, logic cc);
    return {1'b1, TCID3_OP0, TCID3_OP1, TCID3_CRN, TCID3_CRM, TCID3_OP2, el, b, cc};
  endfunction
  // expected {done, undef, trap, target, class, data}
  function automatic logic [74:0] exp_f(logic [27:0] v);
    logic [1:0] el;
    logic [1:0] tel;
    logic h, s, t1, t2, t3, e2, fg, ft, cc;
    {el, h, s, t1, t2, t3, e2, fg, ft, cc} = v[10:0];
    if (v[27:11] != mk(2'h0, 8'h0, 1'b0) >> 11)
      return 75'h0;
    if (el == TCID3_EL0 || (el != TCID3_EL3 && h && s && t3))
      return {3'b110, 72'h0};
    if (el == TCID3_EL1 && t1)
      tel = TCID3_EL1;
    else if (el == TCID3_EL1 && e2 && (t2 || (fg && ft)))
      tel = TCID3_EL2;
    else if (el == TCID3_EL2 && t2)
      tel = TCID3_EL2;
    else if (t3)
      tel = TCID3_EL3;
    else
      return {3'b100, 8'h0, 64'h0d7f0000 | {63'h0, cc}};
    return {3'b101, tel, TCID3_EC_TRAP, 64'h0};
  endfunction
  task automatic step(logic [27:0] v);
    logic [74:0] got;
    {i_rd_valid, i_op0, i_op1, i_crn, i_crm, i_op2, i_current_exception_level, i_halted,
      i_secure_debug_disable, i_el1_trace_trap, i_el2_trace_trap, i_el3_trace_trap,
      i_el2_enabled, i_fine_grained_trap_enable, i_trace_id_read_fine_trap,
      i_cycle_count_trace_support} = v;
    @(posedge i_mclk);
    #1;
    got = {o_rd_done, o_undef, o_trap, o_trap_el, o_trap_class, o_rd_data};
    cmp_count++;
    if (got !== exp_f(v))
    begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp_f(v));
      fails++;
    end
  endtask
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    #20000;
    fails++;
    end_sim();
  end
  initial
  begin
    logic [31:0] r;
    void'($urandom(32'h5d38ee6c));
    repeat (21) @(posedge i_mclk);
    #1 i_rst = 1'b0;
    step(mk(TCID3_EL3, 8'h00, 1'b1));
    step(mk(TCID3_EL3, 8'h00, 1'b1));
    step(mk(TCID3_EL3, 8'h00, 1'b0));
    step(mk(TCID3_EL0, 8'h00, 1'b1));
    step(mk(TCID3_EL1, 8'he8, 1'b1));
    step(mk(TCID3_EL1, 8'h34, 1'b1));
    step(mk(TCID3_EL1, 8'h14, 1'b1));
    step(mk(TCID3_EL1, 8'h07, 1'b1));
    step(mk(TCID3_EL1, 8'h03, 1'b1));
    step(mk(TCID3_EL2, 8'h88, 1'b1));
    step(mk(TCID3_EL2, 8'h18, 1'b1));
    step(mk(TCID3_EL3, 8'hc8, 1'b1));
    step(mk(TCID3_EL3, 8'h00, 1'b1) ^ 28'h0000800);
    step(mk(TCID3_EL0, 8'h00, 1'b1) ^ 28'h8000000);
    $display("test corner done");
    repeat (300)
    begin
      r = $urandom;
      step((r[31:30] != 2'h0) ? mk(r[10:9], r[8:1], r[0]) : r[27:0]);
    end
    step(28'h0);
    $display("test random done");
    end_sim();
  end
endmodule
